// >>> common/vtm_pkg.sv
`default_nettype none
package vtm_pkg;
    // ********************************************
    // Register word indices, byte address = index * 4
    // ********************************************
    localparam logic [5:0] IDX_VOLTAGE_GAIN = 6'h15;
    localparam logic [5:0] IDX_TEMPERATURE_GAIN = 6'h16;
    localparam logic [5:0] IDX_CONTROL_PRIMARY = 6'h17;
    localparam logic [5:0] IDX_CONTROL_SECONDARY = 6'h18;
    localparam logic [5:0] IDX_INPUT0_LIMITS = 6'h19;
    localparam logic [5:0] IDX_ALARM_ENABLE = 6'h1d;
    localparam logic [5:0] IDX_ALARM_STATUS = 6'h30;
    localparam logic [5:0] IDX_ALARM_MASK = 6'h31;
    localparam logic [5:0] IDX_PEAK = 6'h32;
    localparam logic [5:0] IDX_TROUGH = 6'h33;

    // ********************************************
    // Reset values
    // ********************************************
    localparam logic [7:0] RST_VOLTAGE_GAIN = 8'h20;
    localparam logic [7:0] RST_TEMPERATURE_GAIN = 8'h18;
    localparam logic [7:0] RST_CONTROL_PRIMARY = 8'h3c;
    localparam logic [7:0] RST_CONTROL_SECONDARY = 8'h80;
    localparam logic [7:0] RST_INPUT0_LIMITS = 8'h62;
    localparam logic [1:0] RST_ALARM_ENABLE = 2'h0;
    localparam logic [1:0] RST_ALARM_MASK = 2'h0;
    localparam logic [7:0] RST_PEAK = 8'h00;
    localparam logic [7:0] RST_TROUGH = 8'hff;

    // ********************************************
    // Field positions and codes
    // ********************************************
    localparam int GAIN_EN_BIT = 7;
    localparam int SENSE_EN_LSB = 2;
    localparam int PIN0_BIT = 0;
    localparam int PIN1_BIT = 1;
    localparam int UPPER_LSB = 4;
    localparam int LOWER_LSB = 0;
    localparam int HIGH_BIT = 1;
    localparam int LOW_BIT = 0;
    localparam int LEVEL_LSB = 5;
    localparam logic [1:0] SENSE_ON = 2'h3;
    localparam logic [7:0] GAIN_NUMERATOR = 8'h80;
    localparam logic [7:0] UNITY_GAIN = 8'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b01,
        CH_RESP = 2'b10
    } chan_state_type;
endpackage : vtm_pkg
`default_nettype wire

// >>> design/gain_divider.sv
`timescale 1ns/1ps
`default_nettype none
module gain_divider (
    // Gain code
    input wire logic [6:0] code,
    // Integer gain
    output logic [7:0] gain
);
    // Restoring division of a constant numerator, one bit per step
    always_comb begin
        logic [7:0] rem;
        logic [7:0] quo;
        rem = 8'h00;
        quo = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            rem = {rem[6:0], vtm_pkg::GAIN_NUMERATOR[i]};
            if (rem >= {1'b0, code}) begin
                rem = rem - {1'b0, code};
                quo[i] = 1'b1;
            end
        end
        // Zero code has no quotient; saturate to the largest gain
        gain = (code == 7'h00) ? vtm_pkg::GAIN_NUMERATOR : quo;
    end
endmodule : gain_divider
`default_nettype wire

// >>> design/extreme_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module extreme_tracker (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Samples
    input wire logic sample_valid,
    input wire logic [7:0] sample,
    // Extremes
    output logic [7:0] peak_ff,
    output logic [7:0] trough_ff
);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            peak_ff <= vtm_pkg::RST_PEAK;
        end else if (sample_valid && (sample > peak_ff)) begin
            peak_ff <= sample;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trough_ff <= vtm_pkg::RST_TROUGH;
        end else if (sample_valid && (sample < trough_ff)) begin
            trough_ff <= sample;
        end
    end
endmodule : extreme_tracker
`default_nettype wire

// >>> design/voltage_temp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Voltage gain equals 128 divided by the 7-bit code; reset code 0x20.
// - Temperature gain equals 128 divided by its 7-bit code; reset 0x18.
// - Sensors run only when the enable field is 11; reset enabled.
// - Two-bit pin select: none, pin 0, pin 1, both; reset none.
// - Programmed gains apply only while bit 7 of control two is set.
// - Input 0 reading above upper limit sets the high alarm flag.
// - Input 0 reading below lower limit sets the low alarm flag.
// - Highest input 0 reading is kept in a readable register.
// - Lowest input 0 reading is kept in a readable register.
// - Separate enables for high and low alarms, both off at reset.
module voltage_temp_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter samples of input 0
    input wire logic v0_sample_valid,
    input wire logic [7:0] v0_sample,
    // Sensor front end control
    output logic sensors_on,
    output logic general_pin_zero_sense,
    output logic general_pin_one_sense,
    output logic [7:0] voltage_gain_applied,
    output logic [7:0] temperature_gain_applied,
    // Alarms
    output logic sensor_alarm,
    output logic irq
);
    // ********************************************
    // Declarations
    // ********************************************
    vtm_pkg::chan_state_type wr_state_ff;
    vtm_pkg::chan_state_type rd_state_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_held_ff, w_held_ff, wstrb_lo_ff;
    logic [5:0] wr_idx_ff, rd_idx;
    logic [1:0] bresp_ff, rresp_ff;
    logic [7:0] wbyte_ff, rbyte_ff, rd_byte, vgain_eff_ff, tgain_eff_ff;
    logic [7:0] voltage_gain_setting_ff, temperature_gain_setting_ff;
    logic [7:0] monitor_control_primary_ff, monitor_control_secondary_ff;
    logic [7:0] input0_voltage_limits_ff;
    logic [1:0] alarm_enable_ff, status_ff, mask_ff, nxt_status;
    logic sensors_on_ff, over_now_ff, under_now_ff, sensor_alarm_ff, irq_ff;
    logic aw_take, w_take, ar_take, wr_fire, wr_ok, nxt_aw_held, nxt_w_held;
    logic [7:0] vgain_div, tgain_div, applied, input0_peak_reading, input0_trough_reading;
    logic [15:0] product;
    logic [2:0] level, input0_upper_limit, input0_lower_limit;
    logic sense_run, gain_en, meas, hi_cmp, lo_cmp, hi_hit, lo_hit, rd_clear;
    logic input0_high_alarm_on, input0_low_alarm_on;

    function automatic logic is_mapped(input logic [5:0] idx);
        case (idx)
            vtm_pkg::IDX_VOLTAGE_GAIN, vtm_pkg::IDX_TEMPERATURE_GAIN,
            vtm_pkg::IDX_CONTROL_PRIMARY, vtm_pkg::IDX_CONTROL_SECONDARY,
            vtm_pkg::IDX_INPUT0_LIMITS, vtm_pkg::IDX_ALARM_ENABLE,
            vtm_pkg::IDX_ALARM_STATUS, vtm_pkg::IDX_ALARM_MASK,
            vtm_pkg::IDX_PEAK, vtm_pkg::IDX_TROUGH: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // ********************************************
    // Write channel
    // ********************************************
    assign aw_take = awvalid && awready_ff;
    assign w_take = wvalid && wready_ff;
    assign wr_fire = (wr_state_ff == vtm_pkg::CH_IDLE) && aw_held_ff && w_held_ff;
    assign wr_ok = is_mapped(wr_idx_ff);
    assign nxt_aw_held = wr_fire ? 1'b0 : (aw_held_ff || aw_take);
    assign nxt_w_held = wr_fire ? 1'b0 : (w_held_ff || w_take);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            wr_idx_ff <= 6'h00;
            wbyte_ff <= 8'h00;
            wstrb_lo_ff <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            // Address and data are taken in either order, each only once
            awready_ff <= !nxt_aw_held;
            wready_ff <= !nxt_w_held;
            if (aw_take) begin
                wr_idx_ff <= awaddr[7:2];
            end
            if (w_take) begin
                wbyte_ff <= wdata[7:0];
                wstrb_lo_ff <= wstrb[0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_state_ff <= vtm_pkg::CH_IDLE;
            bvalid_ff <= 1'b0;
            bresp_ff <= vtm_pkg::RESP_OKAY;
        end else begin
            case (wr_state_ff)
                vtm_pkg::CH_IDLE: begin
                    if (wr_fire) begin
                        wr_state_ff <= vtm_pkg::CH_RESP;
                        bvalid_ff <= 1'b1;
                        bresp_ff <= wr_ok ? vtm_pkg::RESP_OKAY : vtm_pkg::RESP_SLVERR;
                    end
                end
                vtm_pkg::CH_RESP: begin
                    if (bready) begin
                        wr_state_ff <= vtm_pkg::CH_IDLE;
                        bvalid_ff <= 1'b0;
                    end
                end
                default: begin
                    wr_state_ff <= vtm_pkg::CH_IDLE;
                    bvalid_ff <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************
    // Read channel
    // ********************************************
    assign ar_take = arvalid && arready_ff;
    assign rd_idx = araddr[7:2];
    assign rd_clear = ar_take && (rd_idx == vtm_pkg::IDX_ALARM_STATUS);

    always_comb begin
        case (rd_idx)
            vtm_pkg::IDX_VOLTAGE_GAIN: rd_byte = voltage_gain_setting_ff;
            vtm_pkg::IDX_TEMPERATURE_GAIN: rd_byte = temperature_gain_setting_ff;
            vtm_pkg::IDX_CONTROL_PRIMARY: rd_byte = monitor_control_primary_ff;
            vtm_pkg::IDX_CONTROL_SECONDARY: rd_byte = monitor_control_secondary_ff;
            vtm_pkg::IDX_INPUT0_LIMITS: rd_byte = input0_voltage_limits_ff;
            vtm_pkg::IDX_ALARM_ENABLE: rd_byte = {6'h00, alarm_enable_ff};
            vtm_pkg::IDX_ALARM_STATUS: rd_byte = {6'h00, status_ff};
            vtm_pkg::IDX_ALARM_MASK: rd_byte = {6'h00, mask_ff};
            vtm_pkg::IDX_PEAK: rd_byte = input0_peak_reading;
            vtm_pkg::IDX_TROUGH: rd_byte = input0_trough_reading;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_state_ff <= vtm_pkg::CH_IDLE;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rbyte_ff <= 8'h00;
            rresp_ff <= vtm_pkg::RESP_OKAY;
        end else begin
            case (rd_state_ff)
                vtm_pkg::CH_IDLE: begin
                    if (ar_take) begin
                        rd_state_ff <= vtm_pkg::CH_RESP;
                        arready_ff <= 1'b0;
                        rvalid_ff <= 1'b1;
                        rbyte_ff <= rd_byte;
                        rresp_ff <= is_mapped(rd_idx) ? vtm_pkg::RESP_OKAY : vtm_pkg::RESP_SLVERR;
                    end
                end
                vtm_pkg::CH_RESP: begin
                    if (rready) begin
                        rd_state_ff <= vtm_pkg::CH_IDLE;
                        arready_ff <= 1'b1;
                        rvalid_ff <= 1'b0;
                    end
                end
                default: begin
                    rd_state_ff <= vtm_pkg::CH_IDLE;
                    arready_ff <= 1'b1;
                    rvalid_ff <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************
    // Configuration registers
    // ********************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            voltage_gain_setting_ff <= vtm_pkg::RST_VOLTAGE_GAIN;
            temperature_gain_setting_ff <= vtm_pkg::RST_TEMPERATURE_GAIN;
            monitor_control_primary_ff <= vtm_pkg::RST_CONTROL_PRIMARY;
            monitor_control_secondary_ff <= vtm_pkg::RST_CONTROL_SECONDARY;
            input0_voltage_limits_ff <= vtm_pkg::RST_INPUT0_LIMITS;
            alarm_enable_ff <= vtm_pkg::RST_ALARM_ENABLE;
            mask_ff <= vtm_pkg::RST_ALARM_MASK;
        end else if (wr_fire && wstrb_lo_ff) begin
            case (wr_idx_ff)
                vtm_pkg::IDX_VOLTAGE_GAIN: voltage_gain_setting_ff <= wbyte_ff;
                vtm_pkg::IDX_TEMPERATURE_GAIN: temperature_gain_setting_ff <= wbyte_ff;
                vtm_pkg::IDX_CONTROL_PRIMARY: monitor_control_primary_ff <= wbyte_ff;
                vtm_pkg::IDX_CONTROL_SECONDARY: monitor_control_secondary_ff <= wbyte_ff;
                vtm_pkg::IDX_INPUT0_LIMITS: input0_voltage_limits_ff <= wbyte_ff;
                vtm_pkg::IDX_ALARM_ENABLE: alarm_enable_ff <= wbyte_ff[1:0];
                vtm_pkg::IDX_ALARM_MASK: mask_ff <= wbyte_ff[1:0];
                default: begin
                end
            endcase
        end
    end

    // ********************************************
    // Gain and front end control
    // ********************************************
    assign gain_en = monitor_control_secondary_ff[vtm_pkg::GAIN_EN_BIT];
    assign sense_run = monitor_control_primary_ff[vtm_pkg::SENSE_EN_LSB +: 2]
                       == vtm_pkg::SENSE_ON;

    gain_divider u_vdiv (
        .code(voltage_gain_setting_ff[6:0]),
        .gain(vgain_div)
    );
    gain_divider u_tdiv (
        .code(temperature_gain_setting_ff[6:0]),
        .gain(tgain_div)
    );

    // Gain lags a register write by one cycle; divider kept off the sample path
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vgain_eff_ff <= vtm_pkg::UNITY_GAIN;
            tgain_eff_ff <= vtm_pkg::UNITY_GAIN;
            sensors_on_ff <= 1'b0;
        end else begin
            vgain_eff_ff <= gain_en ? vgain_div : vtm_pkg::UNITY_GAIN;
            tgain_eff_ff <= gain_en ? tgain_div : vtm_pkg::UNITY_GAIN;
            sensors_on_ff <= sense_run;
        end
    end

    // ********************************************
    // Input 0 measurement
    // ********************************************
    assign product = v0_sample * vgain_eff_ff;
    // Saturate instead of wrapping so an overload still reads as high
    assign applied = (product[15:8] != 8'h00) ? 8'hff : product[7:0];
    assign level = applied[vtm_pkg::LEVEL_LSB +: 3];
    assign input0_upper_limit = input0_voltage_limits_ff[vtm_pkg::UPPER_LSB +: 3];
    assign input0_lower_limit = input0_voltage_limits_ff[vtm_pkg::LOWER_LSB +: 3];
    assign meas = v0_sample_valid && sense_run
                  && monitor_control_primary_ff[vtm_pkg::PIN0_BIT];
    assign hi_cmp = level > input0_upper_limit;
    assign lo_cmp = level < input0_lower_limit;
    assign hi_hit = meas && hi_cmp;
    assign lo_hit = meas && lo_cmp;
    assign input0_high_alarm_on = alarm_enable_ff[vtm_pkg::HIGH_BIT];
    assign input0_low_alarm_on = alarm_enable_ff[vtm_pkg::LOW_BIT];

    extreme_tracker u_track (
        .clock(clock),
        .sys_rst(sys_rst),
        .sample_valid(meas),
        .sample(applied),
        .peak_ff(input0_peak_reading),
        .trough_ff(input0_trough_reading)
    );

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            over_now_ff <= 1'b0;
            under_now_ff <= 1'b0;
        end else if (meas) begin
            over_now_ff <= hi_cmp;
            under_now_ff <= lo_cmp;
        end
    end

    // ********************************************
    // Status, alarm and interrupt
    // ********************************************
    // Read clears, but an alarm landing in the same cycle survives
    always_comb begin
        nxt_status = rd_clear ? 2'b00 : status_ff;
        nxt_status[vtm_pkg::HIGH_BIT] = nxt_status[vtm_pkg::HIGH_BIT] | hi_hit;
        nxt_status[vtm_pkg::LOW_BIT] = nxt_status[vtm_pkg::LOW_BIT] | lo_hit;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status_ff <= 2'b00;
            sensor_alarm_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            sensor_alarm_ff <= (over_now_ff && input0_high_alarm_on)
                               || (under_now_ff && input0_low_alarm_on);
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = {24'h00_0000, rbyte_ff};
    assign sensors_on = sensors_on_ff;
    assign general_pin_zero_sense = monitor_control_primary_ff[vtm_pkg::PIN0_BIT];
    assign general_pin_one_sense = monitor_control_primary_ff[vtm_pkg::PIN1_BIT];
    assign voltage_gain_applied = vgain_eff_ff;
    assign temperature_gain_applied = tgain_eff_ff;
    assign sensor_alarm = sensor_alarm_ff;
    assign irq = irq_ff;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_vgain_quad: assert property ((gain_en && voltage_gain_setting_ff[6:0] == 7'h20) [*2]
        |-> vgain_eff_ff == 8'h04) else $error("voltage gain not four");
    a_tgain_value: assert property ((gain_en && temperature_gain_setting_ff[6:0] == 7'h18)
        ##1 gain_en |-> tgain_eff_ff == 8'h05) else $error("temp gain wrong");
    a_sense_gate: assert property (!sense_run |=> !sensors_on_ff && !$past(meas))
        else $error("sensors ran while disabled");
    a_pin_select: assert property ($rose(status_ff[vtm_pkg::HIGH_BIT])
        |-> $past(monitor_control_primary_ff[vtm_pkg::PIN0_BIT]))
        else $error("alarm without pin 0 sensing");
    a_gain_bypass: assert property (!gain_en ##1 !gain_en
        |-> vgain_eff_ff == 8'h01 && tgain_eff_ff == 8'h01)
        else $error("gain applied while disabled");
    a_high_flag: assert property (hi_hit |=> status_ff[vtm_pkg::HIGH_BIT] && over_now_ff)
        else $error("high alarm not set");
    a_low_flag: assert property (lo_hit |=> status_ff[vtm_pkg::LOW_BIT] && under_now_ff)
        else $error("low alarm not set");
    a_peak_hold: assert property (meas |=> input0_peak_reading >= $past(applied))
        else $error("peak below sample");
    a_trough_hold: assert property (meas |=> input0_trough_reading <= $past(applied))
        else $error("trough above sample");
    a_alarm_enable: assert property (alarm_enable_ff == 2'b00 |=> !sensor_alarm_ff)
        else $error("alarm while disabled");
    a_live_update: assert property (meas && !hi_cmp && !lo_cmp
        |=> !over_now_ff && !under_now_ff) else $error("stale level");
endmodule : voltage_temp_monitor
`default_nettype wire

// >>> tb/voltage_temp_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module voltage_temp_monitor_tb;
    logic clock, sys_rst, awvalid, wvalid, bready, arvalid, rready, v0_sample_valid;
    logic awready, wready, bvalid, arready, rvalid, sensors_on, sensor_alarm, irq;
    logic general_pin_zero_sense, general_pin_one_sense;
    logic [7:0] awaddr, araddr, v0_sample, voltage_gain_applied, temperature_gain_applied, c0;
    logic [31:0] wdata, rdata, seed, rd_v;
    logic [3:0] wstrb, ws;
    logic [1:0] bresp, rresp, rs, st, aen, msk, lv;
    logic [5:0] idx_t [10];
    logic [7:0] rv [10];
    logic [7:0] codes [5];
    int n_mismatch, compares, peak, trough, lu, ll, ap, lvl, vg;

    voltage_temp_monitor voltage_temp_monitor_i (.clock, .sys_rst, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .v0_sample_valid, .v0_sample, .sensors_on,
        .general_pin_zero_sense, .general_pin_one_sense, .voltage_gain_applied,
        .temperature_gain_applied, .sensor_alarm, .irq);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    function automatic int gn(input int c, input logic en);
        if (!en) return 1;
        return (c == 0) ? 128 : 128 / c;
    endfunction : gn

    task report_and_stop;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Handshake inputs are judged at the falling edge, acted on after the rising one
    task wr(input logic [5:0] ia, input logic [7:0] d);
        logic a, w, b;
        @(posedge clock);
        awaddr <= {ia, 2'b00};
        wdata <= {24'h0000_00, d};
        wstrb <= ws;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clock);
            a = awready & awvalid;
            w = wready & wvalid;
            @(posedge clock);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while ((awvalid && !a) || (wvalid && !w));
        do begin
            @(negedge clock);
            b = bvalid;
            rs = bresp;
            @(posedge clock);
        end while (!b);
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [5:0] ia);
        logic a, r;
        @(posedge clock);
        araddr <= {ia, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clock);
            a = arready;
            @(posedge clock);
        end while (!a);
        arvalid <= 1'b0;
        do begin
            @(negedge clock);
            r = rvalid;
            rd_v = rdata;
            rs = rresp;
            @(posedge clock);
        end while (!r);
        rready <= 1'b0;
    endtask : rd

    task sm(input logic [7:0] s);
        @(posedge clock);
        v0_sample_valid <= 1'b1;
        v0_sample <= s;
        @(posedge clock);
        v0_sample_valid <= 1'b0;
        if (c0[3:2] == 2'b11 && c0[0]) begin
            ap = (s * vg > 255) ? 255 : s * vg;
            lvl = ap >> 5;
            lv = {lvl > lu, lvl < ll};
            st |= lv;
            if (ap > peak) peak = ap;
            if (ap < trough) trough = ap;
        end
        repeat (2) @(posedge clock);
        #1;
        chk(sensor_alarm, |(lv & aen));
        chk(irq, |(st & msk));
    endtask : sm

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (40000) @(posedge clock);
        n_mismatch++;
        report_and_stop;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {sys_rst, c0} = {1'b1, 8'h3c};
        {awvalid, wvalid, bready, arvalid, rready, v0_sample_valid} = '0;
        {awaddr, araddr, v0_sample, wdata, wstrb} = '0;
        {seed, peak, trough, lu, ll, vg} = {32'h0000_fc35, 32'd0, 32'd255, 32'd6, 32'd2, 32'd4};
        {st, aen, msk, lv} = '0;
        ws = 4'hf;
        idx_t = '{6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1d, 6'h30, 6'h31, 6'h32, 6'h33};
        rv = '{8'h20, 8'h18, 8'h3c, 8'h80, 8'h62, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
        codes = '{8'h40, 8'h10, 8'h00, 8'h7f, 8'h20};
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            rd(idx_t[i]);
            chk(rd_v, rv[i]);
            chk(rs, 2'h0);
        end
        chk(voltage_gain_applied, 8'h04);
        chk(temperature_gain_applied, 8'h05);
        rd(6'h3f);
        chk(rs, 2'h2);
        chk(rd_v, 32'h0000_0000);
        wr(6'h3e, 8'h55);
        chk(rs, 2'h2);
        // Low byte strobe off: write is answered but dropped
        ws = 4'h0;
        wr(6'h15, 8'h7f);
        chk(rs, 2'h0);
        ws = 4'hf;
        rd(6'h15);
        chk(rd_v, 8'h20);
        for (int i = 0; i < 5; i++) begin
            wr(6'h15, codes[i]);
            wr(6'h16, codes[i] ^ 8'h08);
            repeat (2) @(posedge clock);
            chk(voltage_gain_applied, gn(codes[i], 1'b1));
            chk(temperature_gain_applied, gn(codes[i] ^ 8'h08, 1'b1));
        end
        wr(6'h18, 8'h00);
        repeat (2) @(posedge clock);
        chk(voltage_gain_applied, 8'h01);
        chk(temperature_gain_applied, 8'h01);
        wr(6'h18, 8'h80);
        for (int v = 0; v < 16; v++) begin
            c0 = {4'h3, v[3:0]};
            wr(6'h17, c0);
            repeat (2) @(posedge clock);
            chk(sensors_on, c0[3:2] == 2'b11);
            chk({general_pin_one_sense, general_pin_zero_sense}, c0[1:0]);
            seed = xs(seed);
            sm(seed[7:0]);
        end
        c0 = 8'h3d;
        wr(6'h17, c0);
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            if (i % 8 == 0) begin
                {lu, ll, aen, msk} = {29'd0, seed[14:12], 29'd0, seed[10:8], seed[17:14]};
                wr(6'h19, {1'b0, seed[14:12], 1'b0, seed[10:8]});
                wr(6'h1d, {6'h00, aen});
                wr(6'h31, {6'h00, msk});
            end
            sm(seed[7:0]);
            if (i % 5 == 4) begin
                rd(6'h30);
                chk(rd_v, st);
                st = 2'b00;
                rd(6'h32);
                chk(rd_v, peak);
                rd(6'h33);
                chk(rd_v, trough);
            end
        end
        report_and_stop;
    end
endmodule : voltage_temp_monitor_tb
`default_nettype wire
